// ==== core/rsc_top.sv ====
// Reset state controller: sequences processor, backup, peripheral and pin resets.
// Assumes slow clock, power-on cell outputs and reset pin arrive asynchronously to clk_in,
// which serves as the master clock for the APB slave.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "rsc_map.svh"

module rsc_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic slow_clk_in,
	input wire logic backup_por_ok_in,
	input wire logic main_por_ok_in,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_out,
	output logic cpu_rst_n_out,
	output logic backup_rst_n_out,
	output logic periph_rst_n_out,
	output logic cpu_clk_en_out,
	output logic user_irq_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);

	// ==========================================================
	// Input synchronisers
	logic [1:0] slow_sync_q;
	logic slow_prev_q;
	logic [1:0] bpor_sync_q;
	logic [1:0] mpor_sync_q;
	logic [1:0] pin_sync_q;
	logic pin_prev_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slow_sync_q <= 2'h0;
			slow_prev_q <= 1'b0;
			bpor_sync_q <= 2'h0;
			mpor_sync_q <= 2'h0;
			pin_sync_q <= 2'h3;
			pin_prev_q <= 1'b1;
		end else begin
			slow_sync_q <= {slow_sync_q[0], slow_clk_in};
			slow_prev_q <= slow_sync_q[1];
			bpor_sync_q <= {bpor_sync_q[0], backup_por_ok_in};
			mpor_sync_q <= {mpor_sync_q[0], main_por_ok_in};
			pin_sync_q <= {pin_sync_q[0], reset_pin_in};
			pin_prev_q <= pin_sync_q[1];
		end
	end

	wire tick = slow_sync_q[1] & ~slow_prev_q;
	wire bpor_ok = bpor_sync_q[1];
	wire mpor_ok = mpor_sync_q[1];
	wire pin_lvl = pin_sync_q[1];
	wire pin_fall = pin_prev_q & ~pin_lvl;

	// Pin re-sampled on slow ticks; two stages give the slow-clock resync delay
	logic [1:0] pin_slow_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_slow_q <= 2'h3;
		end else if (tick) begin
			pin_slow_q <= {pin_slow_q[0], pin_lvl};
		end
	end
	wire pin_slow = pin_slow_q[1];

	// ==========================================================
	// Registers and APB decode
	rsc_pkg::rsc_mode_s mode_q;
	logic [2:0] last_reset_type_q;
	logic user_reset_seen_flag_q;
	logic sw_cmd_busy_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	wire access = psel_in & penable_in;
	wire done = access & pready_q;
	wire hit_cmd = paddr_in == `RSC_OFS_CMD;
	wire hit_status = paddr_in == `RSC_OFS_STATUS;
	wire hit_mode = paddr_in == `RSC_OFS_MODE;
	wire unmapped = ~(hit_cmd | hit_status | hit_mode);
	wire wr_mode = done & pwrite_in & hit_mode;
	wire rd_status = done & ~pwrite_in & hit_status;
	wire key_ok = pwdata_in[`RSC_CMD_KEY_LSB +: 8] == `RSC_CMD_KEY_VAL;
	wire cpu_reset_cmd = pwdata_in[`RSC_CMD_CPU_BIT];
	wire periph_reset_cmd = pwdata_in[`RSC_CMD_PERIPH_BIT];
	wire pin_reset_cmd = pwdata_in[`RSC_CMD_PIN_BIT];
	wire any_cmd = cpu_reset_cmd | periph_reset_cmd | pin_reset_cmd;
	logic state_run;
	// Ignored while busy or while another reset owns the processor
	wire sw_go = done & pwrite_in & hit_cmd & key_ok & any_cmd & ~sw_cmd_busy_q & state_run;

	wire [31:0] status_word = ({31'h0, user_reset_seen_flag_q} << `RSC_SR_SEEN_BIT)
		| ({29'h0, last_reset_type_q} << `RSC_SR_TYPE_LSB)
		| ({31'h0, pin_lvl} << `RSC_SR_LEVEL_BIT)
		| ({31'h0, sw_cmd_busy_q} << `RSC_SR_BUSY_BIT);
	wire [31:0] mode_word = ({31'h0, mode_q.user_reset_enable} << `RSC_MR_USER_EN_BIT)
		| ({31'h0, mode_q.user_reset_irq_enable} << `RSC_MR_IRQ_EN_BIT)
		| ({28'h0, mode_q.ext_pulse_length_field} << `RSC_MR_LEN_LSB);
	wire [31:0] rd_word = hit_status ? status_word : (hit_mode ? mode_word : 32'h0);

	// One wait state so read data can come from a flip-flop
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= access & ~pready_q;
			pslverr_q <= access & ~pready_q & unmapped;
			prdata_q <= (access & ~pready_q & ~pwrite_in) ? rd_word : 32'h0;
		end
	end

	// Mode register lives in the backup domain: cleared only by rst_n_in and by backup power-on
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q <= '0;
		end else if (!bpor_ok) begin
			mode_q <= '0;
		end else if (wr_mode) begin
			mode_q.user_reset_enable <= pwdata_in[`RSC_MR_USER_EN_BIT];
			mode_q.user_reset_irq_enable <= pwdata_in[`RSC_MR_IRQ_EN_BIT];
			mode_q.ext_pulse_length_field <= pwdata_in[`RSC_MR_LEN_LSB +: 4];
		end
	end

	// ==========================================================
	// Pin pulse shaper
	logic [16:0] pulse_cnt_q;
	logic pin_own_q;
	logic pulse_start;
	// 2^(len+1) cycles; a zero length gives two
	wire [16:0] pulse_len = 17'h2 << mode_q.ext_pulse_length_field;
	wire pulse_busy = pulse_cnt_q != 17'h0;
	// Software pin command loads the shaper alongside state-driven starts
	wire sw_pin_start = sw_go & pin_reset_cmd;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pulse_cnt_q <= 17'h0;
		end else if (pulse_start || sw_pin_start) begin
			pulse_cnt_q <= pulse_len;
		end else if (tick && pulse_busy) begin
			pulse_cnt_q <= pulse_cnt_q - 17'h1;
		end
	end

	// ==========================================================
	// Reset state manager
	rsc_pkg::rsc_state_e state_q;
	rsc_pkg::rsc_state_e state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [2:0] type_d;
	logic sw_cpu_q;
	logic sw_periph_q;
	assign state_run = state_q == rsc_pkg::ST_RUN;

	// A low pin that our own pulse caused must not count as a user reset
	wire user_hit = ~pin_slow & ~pin_own_q & ~pulse_busy & mode_q.user_reset_enable;
	wire cnt_end = cnt_q == 4'h1;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		type_d = last_reset_type_q;
		pulse_start = 1'b0;
		unique case (state_q)
			rsc_pkg::ST_BACKUP_START: begin
				if (tick) begin
					cnt_d = cnt_q - 4'h1;
					if (cnt_end) begin
						state_d = rsc_pkg::ST_BACKUP_HOLD;
						cnt_d = `RSC_HOLD_TICKS;
					end
				end
			end
			rsc_pkg::ST_BACKUP_HOLD: begin
				if (tick) begin
					cnt_d = cnt_q - 4'h1;
					if (cnt_end) begin
						state_d = rsc_pkg::ST_RUN;
						type_d = `RSC_TYPE_GENERAL;
						pulse_start = 1'b1;
					end
				end
			end
			rsc_pkg::ST_WAKE_DOWN: begin
				if (mpor_ok) begin
					state_d = rsc_pkg::ST_WAKE_START;
					cnt_d = `RSC_WAKE_TICKS;
				end
			end
			rsc_pkg::ST_WAKE_START: begin
				if (tick) begin
					cnt_d = cnt_q - 4'h1;
					if (cnt_end) begin
						state_d = rsc_pkg::ST_RUN;
						type_d = `RSC_TYPE_WAKE;
						pulse_start = 1'b1;
					end
				end
			end
			rsc_pkg::ST_RUN: begin
				if (sw_go) begin
					state_d = rsc_pkg::ST_SOFT;
					cnt_d = `RSC_SW_TICKS;
				end else if (user_hit) begin
					state_d = rsc_pkg::ST_USER;
					pulse_start = 1'b1;
				end
			end
			rsc_pkg::ST_USER: begin
				// Stays while the pin is held low from outside
				if (pin_slow && !pulse_busy) begin
					state_d = rsc_pkg::ST_USER_EXIT;
					cnt_d = `RSC_USER_EXIT_TICKS;
				end
			end
			rsc_pkg::ST_USER_EXIT: begin
				if (tick) begin
					cnt_d = cnt_q - 4'h1;
					if (cnt_end) begin
						state_d = rsc_pkg::ST_RUN;
						type_d = `RSC_TYPE_USER;
					end
				end
			end
			rsc_pkg::ST_SOFT: begin
				if (tick) begin
					cnt_d = cnt_q - 4'h1;
					if (cnt_end) begin
						state_d = rsc_pkg::ST_RUN;
						type_d = sw_cpu_q ? `RSC_TYPE_SOFT : last_reset_type_q;
					end
				end
			end
		endcase
		if (!mpor_ok && state_q != rsc_pkg::ST_BACKUP_START && state_q != rsc_pkg::ST_BACKUP_HOLD) begin
			state_d = rsc_pkg::ST_WAKE_DOWN;
			pulse_start = 1'b0;
		end
		if (!bpor_ok) begin
			state_d = rsc_pkg::ST_BACKUP_START;
			cnt_d = `RSC_STARTUP_TICKS;
			pulse_start = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= rsc_pkg::ST_BACKUP_START;
			cnt_q <= `RSC_STARTUP_TICKS;
			last_reset_type_q <= `RSC_TYPE_GENERAL;
			sw_cpu_q <= 1'b0;
			sw_periph_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			last_reset_type_q <= type_d;
			if (sw_go) begin
				sw_cpu_q <= cpu_reset_cmd;
				sw_periph_q <= periph_reset_cmd;
			end else if (state_q != rsc_pkg::ST_SOFT) begin
				sw_cpu_q <= 1'b0;
				sw_periph_q <= 1'b0;
			end
		end
	end

	// Busy set on the write edge, cleared when the software reset is left
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sw_cmd_busy_q <= 1'b0;
		end else if (sw_go) begin
			sw_cmd_busy_q <= 1'b1;
		end else if (state_q == rsc_pkg::ST_SOFT && state_d != rsc_pkg::ST_SOFT) begin
			sw_cmd_busy_q <= 1'b0;
		end else if (state_q != rsc_pkg::ST_SOFT) begin
			sw_cmd_busy_q <= 1'b0;
		end
	end

	// Own-drive mask holds until the slow-sampled pin is seen high again
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_own_q <= 1'b1;
		end else if (reset_pin_oe_out) begin
			pin_own_q <= 1'b1;
		end else if (pin_slow && pin_lvl) begin
			pin_own_q <= 1'b0;
		end
	end

	// ==========================================================
	// Reset outputs from flip-flops, except reset_pin_out, which is tied low
	rsc_pkg::rsc_resets_s assert_d;
	rsc_pkg::rsc_resets_s assert_q;
	wire in_backup = state_d == rsc_pkg::ST_BACKUP_START || state_d == rsc_pkg::ST_BACKUP_HOLD;
	wire in_wake = state_d == rsc_pkg::ST_WAKE_DOWN || state_d == rsc_pkg::ST_WAKE_START;
	wire in_user = state_d == rsc_pkg::ST_USER || state_d == rsc_pkg::ST_USER_EXIT;
	wire in_soft = state_d == rsc_pkg::ST_SOFT;
	wire soft_cpu = sw_go ? cpu_reset_cmd : sw_cpu_q;
	wire soft_periph = sw_go ? periph_reset_cmd : sw_periph_q;

	assign assert_d.cpu = in_backup | in_wake | in_user | (in_soft & soft_cpu);
	assign assert_d.backup = in_backup;
	assign assert_d.periph = in_backup | in_wake | in_user | (in_soft & soft_periph);
	assign assert_d.pin = in_backup | in_wake | pulse_start | sw_pin_start
		| (pulse_busy & ~(tick & pulse_cnt_q == 17'h1));
	wire clk_en_d = state_d != rsc_pkg::ST_BACKUP_START && state_d != rsc_pkg::ST_WAKE_DOWN
		&& state_d != rsc_pkg::ST_USER;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			assert_q <= '1;
			cpu_clk_en_out <= 1'b0;
		end else begin
			assert_q <= assert_d;
			cpu_clk_en_out <= clk_en_d;
		end
	end

	// ==========================================================
	// Seen flag and interrupt
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			user_reset_seen_flag_q <= 1'b0;
			user_irq_out <= 1'b0;
		end else begin
			if (pin_fall) begin
				user_reset_seen_flag_q <= 1'b1;
			end else if (rd_status) begin
				user_reset_seen_flag_q <= 1'b0;
			end
			user_irq_out <= user_reset_seen_flag_q & mode_q.user_reset_irq_enable
				& ~mode_q.user_reset_enable;
		end
	end

	assign cpu_rst_n_out = ~assert_q.cpu;
	assign backup_rst_n_out = ~assert_q.backup;
	assign periph_rst_n_out = ~assert_q.periph;
	assign reset_pin_oe_out = assert_q.pin;
	assign reset_pin_out = 1'b0;
	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;

endmodule : rsc_top

// ==== core/rsc_map.svh ====
// Register offsets, field positions, reset values and timing counts of the reset controller.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define RSC_OFS_CMD 12'h000
`define RSC_OFS_STATUS 12'h004
`define RSC_OFS_MODE 12'h008

// ==========================================================
// Command register fields
`define RSC_CMD_CPU_BIT 0
`define RSC_CMD_PERIPH_BIT 2
`define RSC_CMD_PIN_BIT 3
`define RSC_CMD_KEY_LSB 24
`define RSC_CMD_KEY_VAL 8'ha5

// ==========================================================
// Status register fields
`define RSC_SR_SEEN_BIT 0
`define RSC_SR_TYPE_LSB 8
`define RSC_SR_LEVEL_BIT 16
`define RSC_SR_BUSY_BIT 17

// ==========================================================
// Mode register fields
`define RSC_MR_USER_EN_BIT 0
`define RSC_MR_IRQ_EN_BIT 4
`define RSC_MR_LEN_LSB 8
`define RSC_MR_RESET 32'h0000_0000

// ==========================================================
// Reset type codes
`define RSC_TYPE_GENERAL 3'h0
`define RSC_TYPE_WAKE 3'h1
`define RSC_TYPE_SOFT 3'h3
`define RSC_TYPE_USER 3'h4

// ==========================================================
// Slow clock cycle counts
`define RSC_STARTUP_TICKS 4'h8
`define RSC_HOLD_TICKS 4'h2
`define RSC_WAKE_TICKS 4'h2
`define RSC_USER_EXIT_TICKS 4'h3
`define RSC_SW_TICKS 4'h2

`endif

// ==== core/rsc_pkg.sv ====
// Types shared by the reset controller.
// Assumes rsc_map.svh supplies the numeric constants.
package rsc_pkg;

	typedef enum logic [2:0] {
		ST_BACKUP_START,
		ST_BACKUP_HOLD,
		ST_WAKE_DOWN,
		ST_WAKE_START,
		ST_RUN,
		ST_USER,
		ST_USER_EXIT,
		ST_SOFT
	} rsc_state_e;

	typedef struct packed {
		logic user_reset_enable;
		logic user_reset_irq_enable;
		logic [3:0] ext_pulse_length_field;
	} rsc_mode_s;

	typedef struct packed {
		logic cpu;
		logic backup;
		logic periph;
		logic pin;
	} rsc_resets_s;

endpackage : rsc_pkg

// ==== bench/rsc_top_asserts.sv ====
// Port checks for the reset controller, all in the master clock domain.
// Assumes it is bound to rsc_top from the bench top file.
`timescale 1ns/10ps
module rsc_top_asserts (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic backup_por_ok_in,
	input wire logic main_por_ok_in,
	input wire logic reset_pin_in,
	input wire logic reset_pin_oe_out,
	input wire logic cpu_rst_n_out,
	input wire logic backup_rst_n_out,
	input wire logic periph_rst_n_out,
	input wire logic cpu_clk_en_out,
	input wire logic user_irq_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	input wire logic pslverr_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// ==========
	// Sequences
	sequence cmd_write;
		psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000;
	endsequence
	sequence quiet_run;
		cpu_rst_n_out && periph_rst_n_out && reset_pin_in && main_por_ok_in && backup_por_ok_in;
	endsequence

	// ==========
	// Properties
	pready_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("pready late");
	pready_pulse_a: assert property (pready_out |=> !pready_out)
		else $error("pready held");
	bad_addr_a: assert property (psel_in && penable_in && pready_out && paddr_in > 12'h008
		|-> pslverr_out) else $error("no error on unmapped address");
	backup_drop_a: assert property (!backup_por_ok_in |-> ##[1:4] (!cpu_rst_n_out &&
		!backup_rst_n_out && !periph_rst_n_out && reset_pin_oe_out)) else $error("backup drop");
	main_drop_a: assert property (!main_por_ok_in && backup_por_ok_in |-> ##[1:4]
		(!cpu_rst_n_out && !periph_rst_n_out && reset_pin_oe_out)) else $error("main drop");
	bad_key_a: assert property (cmd_write ##0 quiet_run ##0 pwdata_in[31:24] != 8'ha5
		|=> (cpu_rst_n_out && periph_rst_n_out)[*3]) else $error("bad key obeyed");
	sw_cpu_a: assert property (cmd_write ##0 quiet_run ##0 (!reset_pin_oe_out &&
		pwdata_in[31:24] == 8'ha5 && pwdata_in[0]) |-> ##[1:3] !cpu_rst_n_out)
		else $error("software reset late");
	cpu_release_a: assert property ($rose(cpu_rst_n_out) |-> $past(cpu_clk_en_out))
		else $error("cpu released without clock");
	backup_release_a: assert property ($rose(backup_rst_n_out) |-> reset_pin_oe_out)
		else $error("pin released with backup");
	irq_only_a: assert property ($rose(user_irq_out) |=> cpu_rst_n_out && periph_rst_n_out)
		else $error("interrupt came with reset");
endmodule : rsc_top_asserts

// ==== bench/rsc_pin_model.sv ====
// Reset line shared with outside devices: open drain with a pull-up.
// Assumes the bench decides when an outside device pulls the line.
`timescale 1ns/10ps
module rsc_pin_model (
	input wire logic hold_in,
	input wire logic dut_oe_in,
	input wire logic dut_drive_in,
	output logic line_out
);
	// An outside pull may outlast the block's own pulse
	assign line_out = !((dut_oe_in && !dut_drive_in) || hold_in);
endmodule : rsc_pin_model

// ==== bench/rsc_top_tb.sv ====
// Self-checking bench for the reset controller over APB.
// Assumes rsc_top, rsc_pin_model and rsc_top_asserts are compiled first.
`timescale 1ns/10ps
module rsc_top_tb;
	logic clk_in, slow_clk, rst_n, bpor, mpor, hold, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic pin_out, oe, cpu_n, bkp_n, per_n, clk_en, irq, pready, pslverr, rde;
	wire logic pin_line;
	int err_count = 0, compares = 0, slow_cnt = 0, cpu_falls = 0, bkp_falls = 0;
	int t0, t1, t_ev;
	wire logic [5:0] mon = {clk_en, irq, oe, per_n, bkp_n, cpu_n};

	initial begin
		clk_in = 0;
		forever #2 clk_in = ~clk_in;
	end
	// Slow clock unrelated in phase to the master clock
	initial begin
		slow_clk = 0;
		#3.3;
		forever #48 slow_clk = ~slow_clk;
	end
	always @(posedge slow_clk) slow_cnt <= slow_cnt + 1;
	always @(negedge cpu_n) cpu_falls++;
	always @(negedge bkp_n) bkp_falls++;

	rsc_top uut (.clk_in(clk_in), .rst_n_in(rst_n), .slow_clk_in(slow_clk),
		.backup_por_ok_in(bpor), .main_por_ok_in(mpor), .reset_pin_in(pin_line),
		.reset_pin_out(pin_out), .reset_pin_oe_out(oe), .cpu_rst_n_out(cpu_n),
		.backup_rst_n_out(bkp_n), .periph_rst_n_out(per_n), .cpu_clk_en_out(clk_en),
		.user_irq_out(irq), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr));
	rsc_pin_model line (.hold_in(hold), .dut_oe_in(oe), .dut_drive_in(pin_out),
		.line_out(pin_line));

	// ==========
	// Tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : check

	// Waits as long as the slave needs; only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		rdq = prdata;
		rde = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	// Bounded wait for one watched output, stamping the slow tick count
	task automatic wait_bit(input int i, input logic v);
		int n;
		n = 0;
		while (mon[i] !== v && n < 5000) begin
			@(posedge clk_in);
			n++;
		end
		check("wait", n < 5000, 1);
		t_ev = slow_cnt;
	endtask : wait_bit

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (60000) @(posedge clk_in);
		err_count++;
		give_verdict();
	end

	// ==========
	// Tests
	initial begin
		rst_n = 0;
		bpor = 1;
		mpor = 1;
		hold = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (10) @(posedge clk_in);
		rst_n <= 1;
		t0 = slow_cnt;
		wait_bit(0, 1);
		check("startup", t_ev - t0 >= 10 && t_ev - t0 <= 12, 1);
		check("released", mon, 6'h2f);
		check("pin drive", pin_out, 0);
		t1 = t_ev;
		wait_bit(3, 0);
		check("pin tail", t_ev - t1, 2);
		apb(0, 12'h004, 0);
		check("status", rdq & 32'h0003_0700, 32'h0001_0000);
		apb(0, 12'h008, 0);
		check("mode reset", rdq, 32'h0);
		apb(0, 12'h00c, 0);
		check("unmapped", rde, 1);
		apb(0, 12'h000, 0);
		check("cmd read", rdq, 32'h0);
		apb(1, 12'h008, 32'hffff_ffff);
		apb(0, 12'h008, 0);
		check("mode", rdq, 32'h0000_0f11);
		apb(1, 12'h008, 32'h0000_0101);
		t0 = cpu_falls;
		apb(1, 12'h000, 32'ha500_0004);
		wait_bit(2, 0);
		apb(1, 12'h000, 32'ha500_0001);
		apb(0, 12'h004, 0);
		check("busy", rdq[17], 1);
		wait_bit(2, 1);
		apb(0, 12'h004, 0);
		check("periph only", {rdq[17], rdq[10:8]}, 4'h0);
		check("ignored", cpu_falls - t0, 0);
		apb(1, 12'h000, 32'h5a00_0009);
		repeat (100) @(posedge clk_in);
		check("bad key", cpu_falls - t0, 0);
		check("bad key pins", mon[3:0], 4'h7);
		do begin
			apb(0, 12'h004, 0);
		end while (rdq[17] !== 1'b0);
		apb(1, 12'h000, 32'ha500_0009);
		t0 = slow_cnt;
		repeat (3) @(posedge clk_in);
		check("sw assert", mon[0], 0);
		wait_bit(0, 1);
		check("sw span", t_ev - t0 >= 2 && t_ev - t0 <= 3, 1);
		wait_bit(3, 0);
		check("sw pin", t_ev - t0 >= 4 && t_ev - t0 <= 5, 1);
		repeat (200) @(posedge clk_in);
		check("no user", mon[0], 1);
		apb(0, 12'h004, 0);
		check("type soft", {rdq[10:8], rdq[0]}, 4'h7);
		apb(0, 12'h004, 0);
		check("seen clear", rdq[0], 0);
		apb(1, 12'h008, 32'h0000_0001);
		hold <= 1;
		wait_bit(0, 0);
		wait_bit(2, 0);
		wait_bit(3, 1);
		t0 = t_ev;
		wait_bit(3, 0);
		check("user pulse", t_ev - t0, 2);
		repeat (600) @(posedge clk_in);
		check("held", mon[0], 0);
		hold <= 0;
		t0 = slow_cnt;
		wait_bit(0, 1);
		check("user exit", t_ev - t0 >= 4 && t_ev - t0 <= 7, 1);
		apb(0, 12'h004, 0);
		check("type user", rdq[10:8], 3'h4);
		apb(1, 12'h008, 32'h0000_0010);
		t0 = cpu_falls;
		hold <= 1;
		wait_bit(4, 1);
		apb(0, 12'h004, 0);
		check("level seen", {rdq[16], rdq[0]}, 2'b01);
		repeat (2) @(posedge clk_in);
		check("irq clear", mon[4], 0);
		hold <= 0;
		repeat (100) @(posedge clk_in);
		check("no reset", cpu_falls - t0, 0);
		apb(1, 12'h008, 32'h0000_0100);
		t0 = bkp_falls;
		mpor <= 0;
		repeat (5) @(posedge clk_in);
		check("main low", mon[3:0], 4'ha);
		repeat (100) @(posedge clk_in);
		mpor <= 1;
		t1 = slow_cnt;
		wait_bit(0, 1);
		check("wake span", t_ev - t1 >= 2 && t_ev - t1 <= 5, 1);
		t1 = t_ev;
		wait_bit(3, 0);
		check("wake pin", t_ev - t1 >= 3 && t_ev - t1 <= 5, 1);
		apb(0, 12'h004, 0);
		check("type wake", rdq[10:8], 3'h1);
		apb(0, 12'h008, 0);
		check("mode kept", rdq, 32'h0000_0100);
		check("backup kept", bkp_falls - t0, 0);
		bpor <= 0;
		repeat (5) @(posedge clk_in);
		check("backup low", mon[3:0], 4'h8);
		bpor <= 1;
		wait_bit(0, 1);
		apb(0, 12'h008, 0);
		check("mode cleared", rdq, 32'h0);
		apb(0, 12'h004, 0);
		check("type general", rdq[10:8], 3'h0);
		give_verdict();
	end
endmodule : rsc_top_tb

bind rsc_top rsc_top_asserts chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.backup_por_ok_in(backup_por_ok_in), .main_por_ok_in(main_por_ok_in),
	.reset_pin_in(reset_pin_in), .reset_pin_oe_out(reset_pin_oe_out),
	.cpu_rst_n_out(cpu_rst_n_out), .backup_rst_n_out(backup_rst_n_out),
	.periph_rst_n_out(periph_rst_n_out), .cpu_clk_en_out(cpu_clk_en_out),
	.user_irq_out(user_irq_out), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out));
